// ### rtl/low_power_card_detect_sequencer.sv
// low power card detect sequencer with its apb register file
// assumes gain loop inputs and the field command answer run on pclk;
// slow oscillator, host select and rf level arrive from pins
// the host sets a reference before each start; nothing here checks it
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module low_power_card_detect_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slow_oscillator,
  input wire logic host_select_line_n,
  input wire logic rf_level_detect,
  input wire logic [9:0] gain_loop_value,
  input wire low_power_card_detect_pkg::low_power_card_detect_ref_t gain_loop_config_register,
  input wire logic field_on_command_done,
  output low_power_card_detect_pkg::low_power_card_detect_field_t field_ctrl,
  output logic card_detect_interrupt
);
  logic [15:0] ref_store_ff;
  logic [7:0] field_time_ff;
  logic [7:0] threshold_ff;
  logic [7:0] ref_ctrl_ff;
  logic [7:0] toggle_before_ff;
  logic [7:0] toggle_after_ff;
  logic dpr_en_ff;
  logic [15:0] standby_dur_ff;
  logic irq_ff;
  logic [9:0] last_gain_ff;
  logic [9:0] meas_ref_ff;
  logic ref_pend_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic osc_prev_ff;
  low_power_card_detect_pkg::low_power_card_detect_state_t state_ff;
  logic [15:0] cnt_ff;
  logic leave_ff;
  logic field_ff;
  logic cmd_ff;
  logic aux_ff;
  logic [7:0] idx;
  logic idx_ok;
  logic wr_en;
  logic start_req;
  logic irq_clr;
  logic busy;
  logic [15:0] start_dur;
  logic osc_tick;
  logic stop_req;
  logic detect_hit;
  logic [9:0] ref_val;
  logic [10:0] diff;
  low_power_card_detect_pkg::low_power_card_detect_ref_ctrl_t rctl;

  // status is listed so that reads of it are not refused
  function automatic logic map_hit(input logic [7:0] i);
    case (i)
      low_power_card_detect_pkg::IDX_REF, low_power_card_detect_pkg::IDX_FIELD_TIME,
      low_power_card_detect_pkg::IDX_THRESHOLD, low_power_card_detect_pkg::IDX_REF_CTRL,
      low_power_card_detect_pkg::IDX_TOGGLE_BEFORE, low_power_card_detect_pkg::IDX_TOGGLE_AFTER,
      low_power_card_detect_pkg::IDX_CONTROL, low_power_card_detect_pkg::IDX_STATUS: map_hit = 1'b1;
      default: map_hit = 1'b0;
    endcase
  endfunction : map_hit

  // delay in cycles of a configuration byte of the given unit
  function automatic logic [15:0] delay_cyc(input logic [7:0] b,
                                            input logic [15:0] unit);
    delay_cyc = 16'({8'h00, b} * unit);
  endfunction : delay_cyc

  assign idx = paddr[9:2];
  assign idx_ok = map_hit(idx) && (paddr[1:0] == 2'b00) &&
                  (paddr[31:10] == 22'h00_0000);
  assign wr_en = psel && penable && pwrite && idx_ok;
  assign start_req = wr_en && (idx == low_power_card_detect_pkg::IDX_CONTROL) &&
                     pwdata[low_power_card_detect_pkg::CTL_START];
  assign irq_clr = wr_en && (idx == low_power_card_detect_pkg::IDX_CONTROL) &&
                   pwdata[low_power_card_detect_pkg::CTL_IRQ_CLR];
  // the start write carries its own duration; the stored copy lags a cycle
  assign start_dur = pwdata[low_power_card_detect_pkg::CTL_DUR_LSB +: 16];
  assign busy = state_ff != low_power_card_detect_pkg::ST_IDLE;
  assign rctl = low_power_card_detect_pkg::low_power_card_detect_ref_ctrl_t'(ref_ctrl_ff);
  // no wait states: every answer comes from flops
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;

  // configuration bytes; reset is the only thing that clears them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_store_ff <= low_power_card_detect_pkg::REF_RESET;
      field_time_ff <= low_power_card_detect_pkg::BYTE_RESET;
      threshold_ff <= low_power_card_detect_pkg::BYTE_RESET;
      ref_ctrl_ff <= low_power_card_detect_pkg::BYTE_RESET;
      toggle_before_ff <= low_power_card_detect_pkg::BYTE_RESET;
      toggle_after_ff <= low_power_card_detect_pkg::BYTE_RESET;
      dpr_en_ff <= 1'b0;
      standby_dur_ff <= low_power_card_detect_pkg::REF_RESET;
    end else if (wr_en) begin
      // wr_en already excludes refused addresses, so those never land
      case (idx)
        low_power_card_detect_pkg::IDX_REF: ref_store_ff <= {2'b00, pwdata[13:0]};
        low_power_card_detect_pkg::IDX_FIELD_TIME: field_time_ff <= pwdata[7:0];
        low_power_card_detect_pkg::IDX_THRESHOLD: threshold_ff <= pwdata[7:0];
        low_power_card_detect_pkg::IDX_REF_CTRL: ref_ctrl_ff <= pwdata[7:0];
        low_power_card_detect_pkg::IDX_TOGGLE_BEFORE: toggle_before_ff <= pwdata[7:0];
        low_power_card_detect_pkg::IDX_TOGGLE_AFTER: toggle_after_ff <= pwdata[7:0];
        low_power_card_detect_pkg::IDX_CONTROL: begin
          dpr_en_ff <= pwdata[low_power_card_detect_pkg::CTL_DPR_EN];
          if (pwdata[low_power_card_detect_pkg::CTL_START]) begin
            standby_dur_ff <= pwdata[low_power_card_detect_pkg::CTL_DUR_LSB +: 16];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // read data captured in the setup phase, so the access never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_ff <= !idx_ok;
      prdata_ff <= 32'h0000_0000;
      // refused reads return zero rather than an aliased register
      if (!pwrite && idx_ok) begin
        case (idx)
          low_power_card_detect_pkg::IDX_REF: prdata_ff <= {16'h0000, ref_store_ff};
          low_power_card_detect_pkg::IDX_FIELD_TIME: prdata_ff <= {24'h00_0000, field_time_ff};
          low_power_card_detect_pkg::IDX_THRESHOLD: prdata_ff <= {24'h00_0000, threshold_ff};
          low_power_card_detect_pkg::IDX_REF_CTRL: prdata_ff <= {24'h00_0000, ref_ctrl_ff};
          low_power_card_detect_pkg::IDX_TOGGLE_BEFORE:
            prdata_ff <= {24'h00_0000, toggle_before_ff};
          low_power_card_detect_pkg::IDX_TOGGLE_AFTER:
            prdata_ff <= {24'h00_0000, toggle_after_ff};
          low_power_card_detect_pkg::IDX_CONTROL: begin
            prdata_ff[low_power_card_detect_pkg::CTL_DUR_LSB +: 16] <= standby_dur_ff;
            prdata_ff[low_power_card_detect_pkg::CTL_DPR_EN] <= dpr_en_ff;
          end
          low_power_card_detect_pkg::IDX_STATUS: begin
            prdata_ff[low_power_card_detect_pkg::ST_IRQ] <= irq_ff;
            prdata_ff[low_power_card_detect_pkg::ST_BUSY] <= busy;
            prdata_ff[low_power_card_detect_pkg::ST_REF_PEND] <= ref_pend_ff;
            prdata_ff[low_power_card_detect_pkg::ST_GAIN_LSB +: 10] <= last_gain_ff;
          end
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // pin synchronisers: osc, host select (low = selected), rf level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 3'b010;
      sync2_ff <= 3'b010;
      osc_prev_ff <= 1'b0;
    end else begin
      sync1_ff <= {rf_level_detect, host_select_line_n, slow_oscillator};
      sync2_ff <= sync1_ff;
      osc_prev_ff <= sync2_ff[0];
    end
  end

  // standby resolution is one slow period; the first edge may come early
  assign osc_tick = sync2_ff[0] && !osc_prev_ff;
  assign stop_req = !sync2_ff[1] || sync2_ff[2];

  // reference by source; reserved code falls back to the stored value
  always_comb begin
    case (rctl.source)
      low_power_card_detect_pkg::SRC_MEASURE: ref_val = meas_ref_ff;
      low_power_card_detect_pkg::SRC_GAIN_CFG: ref_val = gain_loop_config_register.value;
      default: ref_val = ref_store_ff[9:0];
    endcase
  end

  assign diff = {1'b0, ref_val} - {1'b0, gain_loop_value};
  // a gain value above the reference wraps negative and never hits
  assign detect_hit = !diff[10] &&
                      (diff[9:0] > {2'b00, threshold_ff});

  // sequencer with one shared delay counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= low_power_card_detect_pkg::ST_IDLE;
      cnt_ff <= 16'h0000;
      leave_ff <= 1'b0;
      field_ff <= 1'b0;
      cmd_ff <= 1'b0;
      aux_ff <= 1'b0;
    end else begin
      cmd_ff <= 1'b0;
      if (cnt_ff != 16'h0000) begin
        cnt_ff <= cnt_ff - 16'h0001;
      end
      case (state_ff)
        low_power_card_detect_pkg::ST_IDLE: begin
          leave_ff <= 1'b0;
          if (start_req) begin
            state_ff <= low_power_card_detect_pkg::ST_STANDBY;
            cnt_ff <= start_dur;
          end
        end
        low_power_card_detect_pkg::ST_STANDBY: begin
          // osc ticks alone move the count; the shared decrement is held
          if (osc_tick && cnt_ff != 16'h0000) begin
            cnt_ff <= cnt_ff - 16'h0001;
          end else if (cnt_ff != 16'h0000) begin
            cnt_ff <= cnt_ff;
          end
          if (stop_req) begin
            state_ff <= low_power_card_detect_pkg::ST_IDLE;
          end else if (cnt_ff == 16'h0000) begin
            if (rctl.aux_enable) begin
              aux_ff <= 1'b1;
              state_ff <= low_power_card_detect_pkg::ST_PRE_AUX;
              cnt_ff <= delay_cyc(toggle_before_ff,
                                  low_power_card_detect_pkg::TOGGLE_UNIT_CYC);
            end else if (dpr_en_ff) begin
              cmd_ff <= 1'b1;
              state_ff <= low_power_card_detect_pkg::ST_FIELD_CMD;
            end else begin
              field_ff <= 1'b1;
              state_ff <= low_power_card_detect_pkg::ST_FIELD_ON;
              cnt_ff <= delay_cyc(field_time_ff,
                                  low_power_card_detect_pkg::FIELD_UNIT_CYC);
            end
          end
        end
        low_power_card_detect_pkg::ST_PRE_AUX: begin
          if (stop_req) begin
            leave_ff <= 1'b1;
            state_ff <= low_power_card_detect_pkg::ST_POST_AUX;
            cnt_ff <= 16'h0000;
          end else if (cnt_ff == 16'h0000) begin
            if (dpr_en_ff) begin
              cmd_ff <= 1'b1;
              state_ff <= low_power_card_detect_pkg::ST_FIELD_CMD;
            end else begin
              field_ff <= 1'b1;
              state_ff <= low_power_card_detect_pkg::ST_FIELD_ON;
              cnt_ff <= delay_cyc(field_time_ff,
                                  low_power_card_detect_pkg::FIELD_UNIT_CYC);
            end
          end
        end
        low_power_card_detect_pkg::ST_FIELD_CMD: begin
          // no timeout on the command answer; only a stop pin gets out
          field_ff <= 1'b1;
          if (stop_req) begin
            field_ff <= 1'b0;
            leave_ff <= 1'b1;
            state_ff <= low_power_card_detect_pkg::ST_POST_AUX;
            cnt_ff <= delay_cyc(toggle_after_ff,
                                low_power_card_detect_pkg::TOGGLE_UNIT_CYC);
          end else if (field_on_command_done) begin
            state_ff <= low_power_card_detect_pkg::ST_FIELD_ON;
            cnt_ff <= delay_cyc(field_time_ff,
                                low_power_card_detect_pkg::FIELD_UNIT_CYC);
          end
        end
        low_power_card_detect_pkg::ST_FIELD_ON: begin
          if (stop_req) begin
            field_ff <= 1'b0;
            leave_ff <= 1'b1;
            state_ff <= low_power_card_detect_pkg::ST_POST_AUX;
            cnt_ff <= delay_cyc(toggle_after_ff,
                                low_power_card_detect_pkg::TOGGLE_UNIT_CYC);
          end else if (cnt_ff == 16'h0000) begin
            state_ff <= low_power_card_detect_pkg::ST_COMPARE;
          end
        end
        low_power_card_detect_pkg::ST_COMPARE: begin
          // stop pins are not looked at here; the post phase catches them
          field_ff <= 1'b0;
          // the measuring pass only fixes the reference
          leave_ff <= detect_hit && !ref_pend_ff;
          state_ff <= low_power_card_detect_pkg::ST_POST_AUX;
          cnt_ff <= delay_cyc(toggle_after_ff,
                              low_power_card_detect_pkg::TOGGLE_UNIT_CYC);
        end
        low_power_card_detect_pkg::ST_POST_AUX: begin
          if (cnt_ff == 16'h0000 || !aux_ff) begin
            aux_ff <= 1'b0;
            if (leave_ff || stop_req) begin
              state_ff <= low_power_card_detect_pkg::ST_IDLE;
            end else begin
              state_ff <= low_power_card_detect_pkg::ST_STANDBY;
              cnt_ff <= standby_dur_ff;
            end
          end
        end
        default: state_ff <= low_power_card_detect_pkg::ST_IDLE;
      endcase
    end
  end

  // gain capture, measured reference and interrupt flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_gain_ff <= 10'h000;
      meas_ref_ff <= 10'h000;
      ref_pend_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      // a stop before the compare leaves the measuring pass pending
      if (start_req && !busy) begin
        ref_pend_ff <= rctl.source == low_power_card_detect_pkg::SRC_MEASURE;
      end
      if (state_ff == low_power_card_detect_pkg::ST_COMPARE) begin
        last_gain_ff <= gain_loop_value;
        if (ref_pend_ff) begin
          meas_ref_ff <= gain_loop_value;
          ref_pend_ff <= 1'b0;
        end
      end
      // set wins over a clear in the same cycle; no config is restored
      if (state_ff == low_power_card_detect_pkg::ST_COMPARE && detect_hit && !ref_pend_ff) begin
        irq_ff <= 1'b1;
      end else if (irq_clr) begin
        irq_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    field_ctrl.field_enable = field_ff;
    field_ctrl.typea_106_select = field_ff && !dpr_en_ff;
    field_ctrl.field_on_command = cmd_ff;
    field_ctrl.aux_output_one = aux_ff;
  end

  assign card_detect_interrupt = irq_ff;
endmodule : low_power_card_detect_sequencer

// ### rtl/low_power_card_detect_pkg.sv
// constants and types of the card detect sequencer
// assumes a 10 MHz pclk and a word-wide apb register bus
package low_power_card_detect_pkg;
  localparam int unsigned CLK_NS = 100;
  // on-time unit and output-toggle unit, in nanoseconds
  localparam int unsigned FIELD_UNIT_NS = 8000;
  localparam int unsigned TOGGLE_UNIT_NS = 5000;
  localparam logic [15:0] FIELD_UNIT_CYC =
    16'((FIELD_UNIT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] TOGGLE_UNIT_CYC =
    16'((TOGGLE_UNIT_NS + CLK_NS - 1) / CLK_NS);

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_REF = 8'h34;
  localparam logic [7:0] IDX_FIELD_TIME = 8'h36;
  localparam logic [7:0] IDX_THRESHOLD = 8'h37;
  localparam logic [7:0] IDX_REF_CTRL = 8'h38;
  localparam logic [7:0] IDX_TOGGLE_BEFORE = 8'h39;
  localparam logic [7:0] IDX_TOGGLE_AFTER = 8'h3A;
  localparam logic [7:0] IDX_CONTROL = 8'h3C;
  localparam logic [7:0] IDX_STATUS = 8'h3D;

  // control register fields
  localparam int unsigned CTL_START = 0;
  localparam int unsigned CTL_DPR_EN = 1;
  localparam int unsigned CTL_IRQ_CLR = 2;
  localparam int unsigned CTL_DUR_LSB = 16;
  // status register fields
  localparam int unsigned ST_IRQ = 0;
  localparam int unsigned ST_BUSY = 1;
  localparam int unsigned ST_REF_PEND = 2;
  localparam int unsigned ST_GAIN_LSB = 16;

  localparam logic [15:0] REF_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // reference source codes
  localparam logic [1:0] SRC_STORED = 2'b00;
  localparam logic [1:0] SRC_MEASURE = 2'b01;
  localparam logic [1:0] SRC_GAIN_CFG = 2'b10;

  typedef struct packed {
    logic [1:0] spare;
    logic [3:0] gear;
    logic [9:0] value;
  } low_power_card_detect_ref_t;

  typedef struct packed {
    logic [4:0] spare;
    logic aux_enable;
    logic [1:0] source;
  } low_power_card_detect_ref_ctrl_t;

  typedef struct packed {
    logic field_enable;
    logic typea_106_select;
    logic field_on_command;
    logic aux_output_one;
  } low_power_card_detect_field_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STANDBY,
    ST_PRE_AUX,
    ST_FIELD_CMD,
    ST_FIELD_ON,
    ST_COMPARE,
    ST_POST_AUX
  } low_power_card_detect_state_t;
endpackage : low_power_card_detect_pkg

// ### dv/low_power_card_detect_sequencer_asserts.sv
// port checker for the card detect sequencer, bound to its top module
// assumes one pclk domain and the async active low presetn
`timescale 1ns/1ps
module low_power_card_detect_sequencer_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic host_select_line_n,
  input wire logic rf_level_detect,
  input wire low_power_card_detect_pkg::low_power_card_detect_field_t field_ctrl,
  input wire logic card_detect_interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic clr_wr;
  assign clr_wr = psel && penable && pwrite && paddr == 32'h0000_00F0 &&
    pwdata[2];

  a_aux_before_field: assert property ($rose(field_ctrl.field_enable) &&
    field_ctrl.aux_output_one |-> $past(field_ctrl.aux_output_one))
    else $error("aux output rose with the field");
  a_aux_after_field: assert property ($fell(field_ctrl.aux_output_one) |->
    !field_ctrl.field_enable && !$past(field_ctrl.field_enable))
    else $error("aux output fell while field on");
  a_typea_needs_field: assert property (field_ctrl.typea_106_select |->
    field_ctrl.field_enable) else $error("type A select without field");
  a_cmd_one_pulse: assert property (field_ctrl.field_on_command |=>
    !field_ctrl.field_on_command) else $error("field command not a pulse");
  a_cmd_keeps_field: assert property (field_ctrl.field_on_command |->
    !field_ctrl.typea_106_select ##1 field_ctrl.field_enable)
    else $error("field command without regulated field");
  a_detect_in_field: assert property ($rose(card_detect_interrupt) |->
    $past(field_ctrl.field_enable)) else $error("interrupt outside detect");
  a_irq_sticky: assert property (card_detect_interrupt && !clr_wr |=>
    card_detect_interrupt) else $error("interrupt dropped without clear");
  a_select_stops: assert property (field_ctrl.field_enable &&
    !host_select_line_n |-> ##[0:6] !field_ctrl.field_enable)
    else $error("host select did not stop the field");
  a_rf_level_stops: assert property (field_ctrl.field_enable &&
    rf_level_detect |-> ##[0:6] !field_ctrl.field_enable)
    else $error("rf level did not stop the field");
  a_err_misalign: assert property (psel && penable && paddr[1:0] != 2'b00
    |-> pslverr) else $error("misaligned access not refused");
  a_err_range: assert property (psel && penable && paddr >= 32'h0000_0400
    |-> pslverr) else $error("out of range access not refused");

  c_irq: cover property ($rose(card_detect_interrupt));
  c_cmd: cover property (field_ctrl.field_on_command);
  c_aux: cover property ($rose(field_ctrl.aux_output_one));
endmodule : low_power_card_detect_sequencer_asserts

bind low_power_card_detect_sequencer low_power_card_detect_sequencer_asserts i_low_power_card_detect_sequencer_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .host_select_line_n(host_select_line_n),
  .rf_level_detect(rf_level_detect), .field_ctrl(field_ctrl),
  .card_detect_interrupt(card_detect_interrupt));

// ### dv/low_power_card_detect_far_model.sv
// far side model: slow oscillator, gain loop and field command answer
// assumes the field controls of the sequencer and gain_set as its only stimulus
`timescale 1ns/1ps
module low_power_card_detect_far_model #(
  parameter int DONE_DLY = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire low_power_card_detect_pkg::low_power_card_detect_field_t field_ctrl,
  input wire logic [9:0] gain_set,
  output logic slow_oscillator,
  output logic [9:0] gain_loop_value,
  output logic field_on_command_done
);
  int cnt;
  // free running, phase unrelated to pclk
  initial slow_oscillator = 1'b0;
  always #2030 slow_oscillator = ~slow_oscillator;
  // no field, no valid gain: show the inverse
  assign gain_loop_value = field_ctrl.field_enable ? gain_set : ~gain_set;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      field_on_command_done <= 1'b0;
    end else begin
      field_on_command_done <= (cnt == 1);
      if (field_ctrl.field_on_command) cnt <= DONE_DLY;
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule : low_power_card_detect_far_model

// ### dv/low_power_card_detect_sequencer_tb_top.sv
// bench for the card detect sequencer: apb tasks and scenario calls
// assumes the far side model answers the field command after 7 cycles
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
  err_total++; $display("wrong value %s exp %h got %h", n, e, g); end end
module low_power_card_detect_sequencer_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic pready, pslverr, sosc, hsel_n = 1, rf_lvl = 0, done, irq;
  logic [9:0] gain_set = 10'h000, gain;
  low_power_card_detect_pkg::low_power_card_detect_ref_t cfg = 16'h0100;
  low_power_card_detect_pkg::low_power_card_detect_field_t fc;
  int err_total = 0, n_checks = 0, aux_rise = 0;
  always #50 pclk = ~pclk;

  low_power_card_detect_sequencer i_low_power_card_detect_sequencer (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_oscillator(sosc), .host_select_line_n(hsel_n),
    .rf_level_detect(rf_lvl), .gain_loop_value(gain),
    .gain_loop_config_register(cfg), .field_on_command_done(done),
    .field_ctrl(fc), .card_detect_interrupt(irq));
  low_power_card_detect_far_model i_low_power_card_detect_far_model (.pclk(pclk), .presetn(presetn),
    .field_ctrl(fc), .gain_set(gain_set), .slow_oscillator(sosc),
    .gain_loop_value(gain), .field_on_command_done(done));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  function automatic logic [31:0] ba(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction : ba
  // counts may slip by one cycle early or up to four cycles late at phase edges
  function automatic int fit(input int g, input int e);
    return (g >= e - 1 && g <= e + 4) ? e : g;
  endfunction : fit
  task automatic apb(input logic w, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin err_total++; give_verdict(); end
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q; logic e;
    apb(1'b1, ba(idx), d, q, e);
  endtask : wr
  task automatic rdc(input string nm, input logic [31:0] a,
      input logic [31:0] x, input logic xe);
    logic [31:0] q; logic e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK(nm, x, q)
    `CHK("pslverr", xe, e)
  endtask : rdc
  // one field phase: aux lead, field on time, aux tail in cycles
  task automatic pass(output int ld, output int on, output int tl);
    int c, ar, fr, ff;
    c = 0; ar = -1; fr = -1; ff = -1;
    while (c < 9000 && !(ff >= 0 && fc.aux_output_one === 1'b0)) begin
      @(negedge pclk); c++;
      if (fc.aux_output_one === 1'b1 && ar < 0) ar = c;
      if (fc.field_enable === 1'b1 && fr < 0) fr = c;
      if (fr >= 0 && fc.field_enable === 1'b0 && ff < 0) ff = c;
    end
    if (c >= 9000) begin err_total++; give_verdict(); end
    ld = fr - ar; on = ff - fr; tl = c - ff;
    aux_rise = ar;
  endtask : pass

  initial begin
    int ld, on, tl, n;
    logic [1:0] src [2] = '{2'b00, 2'b11};
    repeat (2) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
    rdc("ref_rst", ba(low_power_card_detect_pkg::IDX_REF), 32'h0, 1'b0);
    rdc("src_rst", ba(low_power_card_detect_pkg::IDX_REF_CTRL), 32'h0, 1'b0);
    rdc("st_rst", ba(low_power_card_detect_pkg::IDX_STATUS), 32'h0, 1'b0);
    wr(low_power_card_detect_pkg::IDX_REF, 32'hFFFF_FFFF);
    rdc("ref_bits", ba(low_power_card_detect_pkg::IDX_REF), 32'h0000_3FFF, 1'b0);
    rdc("unmapped", 32'h0000_0400, 32'h0, 1'b1);
    rdc("misalign", 32'h0000_00D1, 32'h0, 1'b1);
    wr(low_power_card_detect_pkg::IDX_REF, 32'h0000_0200);
    wr(low_power_card_detect_pkg::IDX_FIELD_TIME, 32'h0000_0002);
    wr(low_power_card_detect_pkg::IDX_THRESHOLD, 32'h0000_0010);
    wr(low_power_card_detect_pkg::IDX_TOGGLE_BEFORE, 32'h0000_0002);
    wr(low_power_card_detect_pkg::IDX_TOGGLE_AFTER, 32'h0000_0001);
    $display("test registers done");
    // no detect at the threshold itself, then stop by either pin
    wr(low_power_card_detect_pkg::IDX_REF_CTRL, 32'h0000_0004);
    gain_set <= 10'h1F0;
    for (int k = 0; k < 2; k++) begin
      wr(low_power_card_detect_pkg::IDX_CONTROL, 32'h0002_0001);
      pass(ld, on, tl);
      `CHK("standby", 1'b1, aux_rise >= 40 && aux_rise <= 90)
      `CHK("lead", 100, fit(ld, 100))
      `CHK("on", 160, fit(on, 160))
      `CHK("tail", 50, fit(tl, 50))
      `CHK("no_irq", 1'b0, irq)
      n = 0;
      while (fc.field_enable !== 1'b1 && n < 9000) begin
        @(negedge pclk); n++;
      end
      if (n >= 9000) begin err_total++; give_verdict(); end
      `CHK("typea", 1'b1, fc.typea_106_select)
      @(posedge pclk);
      if (k == 0) hsel_n <= 1'b0;
      else rf_lvl <= 1'b1;
      pass(ld, on, tl);
      `CHK("stop_tail", 50, fit(tl, 50))
      rdc("stopped", ba(low_power_card_detect_pkg::IDX_STATUS), 32'h01F0_0000, 1'b0);
      hsel_n <= 1'b1; rf_lvl <= 1'b0;
      repeat (5) @(posedge pclk);
    end
    $display("test loop and stop done");
    gain_set <= 10'h1E0;
    for (int k = 0; k < 2; k++) begin
      wr(low_power_card_detect_pkg::IDX_REF_CTRL, {30'h0, src[k]});
      wr(low_power_card_detect_pkg::IDX_CONTROL, 32'h0001_0001);
      pass(ld, on, tl);
      repeat (5) @(negedge pclk);
      `CHK("irq", 1'b1, irq)
      `CHK("aux_off", -1, aux_rise)
      rdc("hit", ba(low_power_card_detect_pkg::IDX_STATUS), 32'h01E0_0001, 1'b0);
      wr(low_power_card_detect_pkg::IDX_CONTROL, 32'h0000_0004);
      @(negedge pclk);
      `CHK("irq_clr", 1'b0, irq)
    end
    $display("test stored reference done");
    wr(low_power_card_detect_pkg::IDX_REF_CTRL, 32'h0000_0002);
    gain_set <= 10'h0E0;
    wr(low_power_card_detect_pkg::IDX_CONTROL, 32'h0001_0003);
    pass(ld, on, tl);
    `CHK("dpr_on", 168, fit(on, 168))
    repeat (5) @(negedge pclk);
    `CHK("dpr_irq", 1'b1, irq)
    wr(low_power_card_detect_pkg::IDX_CONTROL, 32'h0000_0004);
    $display("test regulated field done");
    wr(low_power_card_detect_pkg::IDX_REF_CTRL, 32'h0000_0001);
    gain_set <= 10'h300;
    wr(low_power_card_detect_pkg::IDX_CONTROL, 32'h0001_0001);
    pass(ld, on, tl);
    `CHK("capture", 1'b0, irq)
    @(posedge pclk);
    gain_set <= 10'h2C0;
    pass(ld, on, tl);
    repeat (5) @(negedge pclk);
    rdc("measured", ba(low_power_card_detect_pkg::IDX_STATUS), 32'h02C0_0001, 1'b0);
    $display("test measured reference done");
    give_verdict();
  end
endmodule : low_power_card_detect_sequencer_tb_top
